// ==== inc/usbsof_pkg.sv ====
// Constants for the host SOF and frame timing block
package usbsof_pkg;

    // Register byte offsets
    localparam logic [7:0] USBSOF_OFS_ADDR = 8'h00;
    localparam logic [7:0] USBSOF_OFS_GUARD = 8'h04;
    localparam logic [7:0] USBSOF_OFS_FRAME = 8'h08;
    localparam logic [7:0] USBSOF_OFS_TOKEN = 8'h0C;
    localparam logic [7:0] USBSOF_OFS_STATE = 8'h10;
    localparam logic [7:0] USBSOF_OFS_CTRL = 8'h14;

    // Field positions and widths
    localparam int USBSOF_ADDR_LSB = 8;
    localparam int USBSOF_ADDR_W = 7;
    localparam int USBSOF_GUARD_W = 14;
    localparam int USBSOF_FRAME_W = 11;
    localparam int USBSOF_ENDP_W = 4;
    localparam int USBSOF_CMD_LSB = 4;
    localparam int USBSOF_CMD_W = 3;
    localparam int USBSOF_TIMER_W = 14;

    // Values after reset
    localparam logic [USBSOF_ADDR_W-1:0] USBSOF_ADDR_RST = 7'h00;
    localparam logic [USBSOF_GUARD_W-1:0] USBSOF_GUARD_RST = 14'h0000;
    localparam logic [USBSOF_FRAME_W-1:0] USBSOF_FRAME_RST = 11'h000;

    // Token command codes
    localparam logic [2:0] USBSOF_CMD_NONE = 3'h0;
    localparam logic [2:0] USBSOF_CMD_SETUP = 3'h1;
    localparam logic [2:0] USBSOF_CMD_IN = 3'h2;
    localparam logic [2:0] USBSOF_CMD_OUT = 3'h3;
    localparam logic [2:0] USBSOF_CMD_SOF = 3'h4;
    localparam logic [2:0] USBSOF_CMD_ISO_IN = 3'h5;
    localparam logic [2:0] USBSOF_CMD_ISO_OUT = 3'h6;
    localparam logic [2:0] USBSOF_CMD_RSVD = 3'h7;

    // Timing: core clock, bus bit rate and frame period
    localparam int USBSOF_CLK_PERIOD_NS = 100;
    localparam int USBSOF_CLK_KHZ = 1000000 / USBSOF_CLK_PERIOD_NS;
    localparam int USBSOF_BIT_RATE_KHZ = 12000;
    localparam int USBSOF_FRAME_US = 1000;
    localparam int USBSOF_FRAME_BITS = USBSOF_FRAME_US * USBSOF_BIT_RATE_KHZ / 1000;

endpackage

// ==== verilog/usbsof_bit_tick.sv ====
// Fractional bit-time step generator for the SOF timer
`timescale 1ns/1ps
`default_nettype none

module usbsof_bit_tick
    import usbsof_pkg::*;
#(
    parameter int CLK_KHZ = USBSOF_CLK_KHZ,
    parameter int BIT_KHZ = USBSOF_BIT_RATE_KHZ
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    output logic [1:0] steps_out
);

    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] sum;

    // Accumulate bit rate per clock, emit 0 to 2 whole bit times
    always_comb begin
        sum = acc_r + 32'(BIT_KHZ);
        acc_nxt = sum;
        steps_out = 2'h0;
        if (!run_in) begin
            acc_nxt = 32'h0;
        end else if (sum >= 32'(2 * CLK_KHZ)) begin
            acc_nxt = sum - 32'(2 * CLK_KHZ);
            steps_out = 2'h2;
        end else if (sum >= 32'(CLK_KHZ)) begin
            acc_nxt = sum - 32'(CLK_KHZ);
            steps_out = 2'h1;
        end
    end

    // Accumulator register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            acc_r <= 32'h0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== verilog/usbsof_top.sv ====
// Host token address, end-of-frame guard and SOF frame timing with APB registers
//
// Summary of operation
// - Every setup, in, out and iso token sent carries the 7-bit address held in bits 14:8 of the address register.
// - Reserved bits of the address, guard and frame registers ignore writes and read as zero.
// - Token address and guard time survive the controller soft reset.
// - A setup, in or out token pending in the guard window waits until the automatic SOF is done.
// - The guard window is open while the SOF timer is running and below the programmed guard time.
// - The guard time is a 14-bit count of bus bit times in bits 13:0.
// - Writing the SOF command code starts the SOF timer.
// - A running SOF timer sends an SOF token every 1 ms with no further commands.
// - Each SOF carries the 11-bit frame number from bits 10:0 of the frame register.
// - The frame number goes up by one when each SOF transmission completes.
// - The controller soft reset returns the frame number to its initial value.
`timescale 1ns/1ps
`default_nettype none

module usbsof_top
    import usbsof_pkg::*;
#(
    parameter int FRAME_BITS = USBSOF_FRAME_BITS
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Token request to the packet engine
    output logic tok_valid_out,
    output logic [2:0] tok_kind_out,
    output logic [USBSOF_ADDR_W-1:0] tok_addr_out,
    output logic [USBSOF_ENDP_W-1:0] tok_endp_out,
    output logic [USBSOF_FRAME_W-1:0] tok_frame_out,
    input wire logic tok_done_in,
    // Status
    output logic sof_busy_out
);

    typedef enum {ST_IDLE, ST_SOF, ST_TOKEN} usbsof_state_e;

    // Tokens that the guard window holds back
    function automatic logic is_data_token(input logic [2:0] code);
        return (code == USBSOF_CMD_SETUP) || (code == USBSOF_CMD_IN) || (code == USBSOF_CMD_OUT) ||
               (code == USBSOF_CMD_ISO_IN) || (code == USBSOF_CMD_ISO_OUT);
    endfunction

    // Register state
    logic [USBSOF_ADDR_W-1:0] addr_r, addr_nxt;
    logic [USBSOF_GUARD_W-1:0] guard_r, guard_nxt;
    logic [USBSOF_FRAME_W-1:0] frame_r, frame_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic [USBSOF_ENDP_W-1:0] endp_r, endp_nxt;
    logic soft_rst_r, soft_rst_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    // Frame timing state
    logic [USBSOF_TIMER_W-1:0] timer_r, timer_nxt;
    logic running_r, running_nxt;
    logic sof_due_r, sof_due_nxt;
    usbsof_state_e state_r, state_nxt;
    logic tok_valid_r, tok_valid_nxt;
    logic [2:0] tok_kind_r, tok_kind_nxt;
    logic [USBSOF_ADDR_W-1:0] tok_addr_r, tok_addr_nxt;
    logic [USBSOF_ENDP_W-1:0] tok_endp_r, tok_endp_nxt;
    logic [USBSOF_FRAME_W-1:0] tok_frame_r, tok_frame_nxt;
    logic sof_busy_r, sof_busy_nxt;

    logic [1:0] steps;
    logic wr_fire;
    logic rd_fire;
    logic sof_done;
    logic in_guard;

    // Bit-time steps for the SOF timer
    usbsof_bit_tick #(
        .CLK_KHZ(USBSOF_CLK_KHZ),
        .BIT_KHZ(USBSOF_BIT_RATE_KHZ)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(running_r),
        .steps_out(steps)
    );

    // Bus transfer completes on the edge where pready is high
    assign wr_fire = psel_in && penable_in && pready_r && pwrite_in;
    assign rd_fire = psel_in && penable_in && !pready_r && !pwrite_in;
    assign sof_done = (state_r == ST_SOF) && tok_done_in;
    assign in_guard = running_r && (timer_r < guard_r);

    // APB answer: one wait state, read data and error captured with it
    always_comb begin
        pready_nxt = psel_in && penable_in && !pready_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            prdata_nxt = 32'h0;
            case (paddr_in)
                USBSOF_OFS_ADDR: prdata_nxt[USBSOF_ADDR_LSB +: USBSOF_ADDR_W] = addr_r;
                USBSOF_OFS_GUARD: prdata_nxt[USBSOF_GUARD_W-1:0] = guard_r;
                USBSOF_OFS_FRAME: prdata_nxt[USBSOF_FRAME_W-1:0] = frame_r;
                USBSOF_OFS_TOKEN: begin
                    prdata_nxt[USBSOF_CMD_LSB +: USBSOF_CMD_W] = cmd_r;
                    prdata_nxt[USBSOF_ENDP_W-1:0] = endp_r;
                end
                USBSOF_OFS_STATE: prdata_nxt[2:0] = {in_guard, running_r, sof_busy_r};
                USBSOF_OFS_CTRL: prdata_nxt[0] = soft_rst_r;
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (rd_fire && 1'b0) begin
            prdata_nxt = 32'h0;
        end
    end

    // Software-written registers
    always_comb begin
        addr_nxt = addr_r;
        guard_nxt = guard_r;
        frame_nxt = frame_r;
        cmd_nxt = cmd_r;
        endp_nxt = endp_r;
        soft_rst_nxt = soft_rst_r;
        if (wr_fire) begin
            case (paddr_in)
                USBSOF_OFS_ADDR: addr_nxt = pwdata_in[USBSOF_ADDR_LSB +: USBSOF_ADDR_W];
                USBSOF_OFS_GUARD: guard_nxt = pwdata_in[USBSOF_GUARD_W-1:0];
                USBSOF_OFS_FRAME: frame_nxt = pwdata_in[USBSOF_FRAME_W-1:0];
                USBSOF_OFS_TOKEN: begin
                    // A new command is only taken when idle and not reserved
                    if (cmd_r == USBSOF_CMD_NONE && !soft_rst_r &&
                        pwdata_in[USBSOF_CMD_LSB +: USBSOF_CMD_W] != USBSOF_CMD_RSVD) begin
                        cmd_nxt = pwdata_in[USBSOF_CMD_LSB +: USBSOF_CMD_W];
                        endp_nxt = pwdata_in[USBSOF_ENDP_W-1:0];
                    end
                end
                USBSOF_OFS_CTRL: soft_rst_nxt = pwdata_in[0];
                default: ;
            endcase
        end
        // Completion clears the command; SOF completion advances the frame
        if (sof_done) begin
            frame_nxt = frame_r + 11'h001;
            if (cmd_r == USBSOF_CMD_SOF) begin
                cmd_nxt = USBSOF_CMD_NONE;
            end
        end
        if (state_r == ST_TOKEN && tok_done_in) begin
            cmd_nxt = USBSOF_CMD_NONE;
        end
        // Soft reset clears frame and command, keeps address and guard
        if (soft_rst_r) begin
            frame_nxt = USBSOF_FRAME_RST;
            cmd_nxt = USBSOF_CMD_NONE;
            endp_nxt = 4'h0;
        end
    end

    // SOF timer: bit times left in the frame, reload at each SOF
    always_comb begin
        timer_nxt = timer_r;
        running_nxt = running_r;
        sof_due_nxt = sof_due_r;
        if (state_r == ST_IDLE && sof_due_r) begin
            sof_due_nxt = 1'b0;
        end
        if (wr_fire && paddr_in == USBSOF_OFS_TOKEN && !running_r && !soft_rst_r &&
            cmd_r == USBSOF_CMD_NONE &&
            pwdata_in[USBSOF_CMD_LSB +: USBSOF_CMD_W] == USBSOF_CMD_SOF) begin
            running_nxt = 1'b1;
            sof_due_nxt = 1'b1;
            timer_nxt = USBSOF_TIMER_W'(FRAME_BITS);
        end else if (running_r) begin
            if ({12'h000, steps} >= timer_r) begin
                sof_due_nxt = 1'b1;
                timer_nxt = USBSOF_TIMER_W'(FRAME_BITS);
            end else begin
                timer_nxt = timer_r - {12'h000, steps};
            end
        end
        if (soft_rst_r) begin
            running_nxt = 1'b0;
            sof_due_nxt = 1'b0;
            timer_nxt = 14'h0000;
        end
    end

    // Token scheduler: SOF first, data tokens only outside the guard window
    always_comb begin
        state_nxt = state_r;
        tok_valid_nxt = tok_valid_r;
        tok_kind_nxt = tok_kind_r;
        tok_addr_nxt = tok_addr_r;
        tok_endp_nxt = tok_endp_r;
        tok_frame_nxt = tok_frame_r;
        case (state_r)
            ST_IDLE: begin
                if (sof_due_r) begin
                    state_nxt = ST_SOF;
                    tok_valid_nxt = 1'b1;
                    tok_kind_nxt = USBSOF_CMD_SOF;
                    tok_frame_nxt = frame_r;
                end else if (is_data_token(cmd_r) && !in_guard) begin
                    state_nxt = ST_TOKEN;
                    tok_valid_nxt = 1'b1;
                    tok_kind_nxt = cmd_r;
                    tok_addr_nxt = addr_r;
                    tok_endp_nxt = endp_r;
                end
            end
            ST_SOF, ST_TOKEN: begin
                if (tok_done_in) begin
                    state_nxt = ST_IDLE;
                    tok_valid_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                tok_valid_nxt = 1'b0;
            end
        endcase
        if (soft_rst_r) begin
            state_nxt = ST_IDLE;
            tok_valid_nxt = 1'b0;
        end
        sof_busy_nxt = (state_nxt == ST_SOF) || sof_due_nxt;
    end

    // Bus and software register flops; address and guard ignore soft reset
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            addr_r <= USBSOF_ADDR_RST;
            guard_r <= USBSOF_GUARD_RST;
            frame_r <= USBSOF_FRAME_RST;
            cmd_r <= USBSOF_CMD_NONE;
            endp_r <= 4'h0;
            soft_rst_r <= 1'b0;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            addr_r <= addr_nxt;
            guard_r <= guard_nxt;
            frame_r <= frame_nxt;
            cmd_r <= cmd_nxt;
            endp_r <= endp_nxt;
            soft_rst_r <= soft_rst_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Timing and scheduler flops
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            timer_r <= 14'h0000;
            running_r <= 1'b0;
            sof_due_r <= 1'b0;
            state_r <= ST_IDLE;
            tok_valid_r <= 1'b0;
            tok_kind_r <= USBSOF_CMD_NONE;
            tok_addr_r <= USBSOF_ADDR_RST;
            tok_endp_r <= 4'h0;
            tok_frame_r <= USBSOF_FRAME_RST;
            sof_busy_r <= 1'b0;
        end else begin
            timer_r <= timer_nxt;
            running_r <= running_nxt;
            sof_due_r <= sof_due_nxt;
            state_r <= state_nxt;
            tok_valid_r <= tok_valid_nxt;
            tok_kind_r <= tok_kind_nxt;
            tok_addr_r <= tok_addr_nxt;
            tok_endp_r <= tok_endp_nxt;
            tok_frame_r <= tok_frame_nxt;
            sof_busy_r <= sof_busy_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign tok_valid_out = tok_valid_r;
    assign tok_kind_out = tok_kind_r;
    assign tok_addr_out = tok_addr_r;
    assign tok_endp_out = tok_endp_r;
    assign tok_frame_out = tok_frame_r;
    assign sof_busy_out = sof_busy_r;

endmodule

`default_nettype wire

// ==== sim/usbsof_top_properties.sv ====
// Concurrent checks on the ports of the SOF and frame timing block
`timescale 1ns/1ps
`default_nettype none

module usbsof_top_properties
    import usbsof_pkg::*;
#(
    parameter int FRAME_BITS = USBSOF_FRAME_BITS
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic tok_valid_out,
    input wire logic [2:0] tok_kind_out,
    input wire logic [USBSOF_ADDR_W-1:0] tok_addr_out,
    input wire logic [USBSOF_ENDP_W-1:0] tok_endp_out,
    input wire logic [USBSOF_FRAME_W-1:0] tok_frame_out,
    input wire logic tok_done_in,
    input wire logic sof_busy_out
);
    localparam int FCLK = FRAME_BITS * 5 / 6;
    logic wr_en;
    logic sof_up;
    logic tok_q_r;
    logic soft_r;
    logic run_r;
    logic [6:0] addr_r;
    logic [13:0] guard_r;
    logic [10:0] frame_r;
    logic [15:0] cyc_r;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Accepted writes and start of each SOF token
    assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
    assign sof_up = tok_valid_out && !tok_q_r && tok_kind_out == USBSOF_CMD_SOF;

    // Shadow of software settings and clocks since the last SOF
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            {tok_q_r, soft_r, run_r, addr_r, guard_r, frame_r, cyc_r} <= '0;
        end else begin
            tok_q_r <= tok_valid_out;
            cyc_r <= sof_up ? 16'h0001 : cyc_r + 16'h0001;
            frame_r <= sof_up ? tok_frame_out : frame_r;
            run_r <= sof_up || (run_r && !(wr_en && paddr_in inside {USBSOF_OFS_FRAME, USBSOF_OFS_CTRL}));
            addr_r <= (wr_en && paddr_in == USBSOF_OFS_ADDR) ? pwdata_in[14:8] : addr_r;
            guard_r <= (wr_en && paddr_in == USBSOF_OFS_GUARD) ? pwdata_in[13:0] : guard_r;
            soft_r <= (wr_en && paddr_in == USBSOF_OFS_CTRL) ? pwdata_in[0] : soft_r;
        end
    end

    a_ready_one_wait: assert property ((psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out)
        else $error("ready not in second access cycle");
    a_slverr_map: assert property (pready_out |-> pslverr_out == (paddr_in > USBSOF_OFS_CTRL || paddr_in[1:0] != 2'h0))
        else $error("error response does not match address map");
    a_token_hold: assert property (tok_valid_out && !tok_done_in && !soft_r
        && !(wr_en && paddr_in == USBSOF_OFS_CTRL) |=> tok_valid_out && $stable(tok_kind_out)
        && $stable(tok_addr_out) && $stable(tok_endp_out) && $stable(tok_frame_out))
        else $error("token changed early");
    a_sof_start: assert property (wr_en && paddr_in == USBSOF_OFS_TOKEN && pwdata_in[6:4] == USBSOF_CMD_SOF
        && !soft_r && !tok_valid_out && !sof_busy_out |=> sof_busy_out ##1 (tok_valid_out
        && tok_kind_out == USBSOF_CMD_SOF)) else $error("SOF command did not start an SOF");
    a_sof_frame_step: assert property (sof_up && run_r |-> tok_frame_out == frame_r + 11'h001)
        else $error("frame number did not step by one");
    a_sof_period: assert property (sof_up && run_r |-> cyc_r inside {[FCLK-3:FCLK+3]})
        else $error("SOF spacing wrong");
    a_guard_held: assert property ($rose(tok_valid_out) && tok_kind_out inside {[3'h1:3'h3]} && run_r
        |-> (FCLK - int'(cyc_r)) * 6 + 12 >= int'(guard_r) * 5) else $error("data token sent in guard window");
    a_sof_done_idle: assert property (tok_valid_out && tok_done_in && tok_kind_out == USBSOF_CMD_SOF
        |=> !tok_valid_out && !sof_busy_out) else $error("SOF did not finish");
    a_token_address: assert property ($rose(tok_valid_out) && tok_kind_out != USBSOF_CMD_SOF
        |-> tok_addr_out == addr_r) else $error("token address wrong");
    a_soft_idle: assert property (soft_r |=> !tok_valid_out && !sof_busy_out)
        else $error("activity during soft reset");
endmodule

bind usbsof_top usbsof_top_properties #(.FRAME_BITS(FRAME_BITS)) u_props (.core_clk_in, .sys_rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tok_valid_out,
    .tok_kind_out, .tok_addr_out, .tok_endp_out, .tok_frame_out, .tok_done_in, .sof_busy_out);

`default_nettype wire

// ==== sim/usbsof_engine_model.sv ====
// Packet engine and attached function seen from the token link
`timescale 1ns/1ps
`default_nettype none

module usbsof_engine_model (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic tok_valid_in,
    input wire logic [3:0] delay_in,
    output logic tok_done_out
);
    logic [4:0] wait_r;

    // Spend a short packet time, then a one-cycle done
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in || !tok_valid_in || tok_done_out) begin
            wait_r <= 5'h00;
            tok_done_out <= 1'b0;
        end else begin
            wait_r <= wait_r + 5'h01;
            tok_done_out <= (wait_r == {1'b0, delay_in});
        end
    end
endmodule

`default_nettype wire

// ==== sim/usbsof_top_bench.sv ====
// Self-checking bench for the SOF and frame timing block
`timescale 1ns/1ps
`default_nettype none

module usbsof_top_bench
    import usbsof_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, done, pready, pslverr, tvalid, busy;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] tkind;
    logic [6:0] taddr;
    logic [3:0] tendp, dly = 4'h0;
    logic [10:0] tframe;
    int err_total = 0, tests_run = 0;

    always #50 clk = ~clk;

    usbsof_top #(.FRAME_BITS(240)) dut (.core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .tok_valid_out(tvalid), .tok_kind_out(tkind), .tok_addr_out(taddr),
        .tok_endp_out(tendp), .tok_frame_out(tframe), .tok_done_in(done), .sof_busy_out(busy));
    usbsof_engine_model eng (.core_clk_in(clk), .sys_rst_in(rst), .tok_valid_in(tvalid), .delay_in(dly),
        .tok_done_out(done));

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, held until ready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check("read data", q, exp);
        check("error response", {31'h0, e}, {31'h0, err});
    endtask

    // Wait for the next token, compare its fields, wait for its end
    task automatic expect_tok(input logic [2:0] k, input logic [6:0] a, input logic [3:0] ep, input logic [10:0] f);
        int n;
        n = 0;
        while (tvalid !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check("token start", {31'h0, tvalid}, 32'h1);
        check("token kind", {29'h0, tkind}, {29'h0, k});
        if (k == USBSOF_CMD_SOF) begin
            check("sof frame", {21'h0, tframe}, {21'h0, f});
        end else begin
            check("token address", {25'h0, taddr}, {25'h0, a});
            check("token endpoint", {28'h0, tendp}, {28'h0, ep});
        end
        while (tvalid === 1'b1 && n < 800) begin
            @(posedge clk);
            n++;
        end
        check("token end", {31'h0, tvalid}, 32'h0);
    endtask

    function automatic logic [31:0] reg_mask(input logic [7:0] a, input logic [31:0] d);
        case (a)
            USBSOF_OFS_ADDR: return d & 32'h7F00;
            USBSOF_OFS_GUARD: return d & 32'h3FFF;
            default: return d & 32'h7FF;
        endcase
    endfunction

    initial begin
        #(100 * 5000);
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] v;
        logic [7:0] ra;
        logic [6:0] ad;
        logic [10:0] fr;
        void'($urandom(32'h71834FA0));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped place, random writes with reserved bits
        for (int i = 0; i < 3; i++) rd(8'(4 * i), 32'h0, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        rd(8'h05, 32'h0, 1'b1);
        for (int i = 0; i < 12; i++) begin
            ra = 8'(4 * (i % 3));
            v = $urandom();
            wr(ra, v);
            rd(ra, reg_mask(ra, v), 1'b0);
        end
        // Reserved command code is refused
        wr(USBSOF_OFS_TOKEN, 32'h7F);
        rd(USBSOF_OFS_TOKEN, 32'h0, 1'b0);
        ad = 7'($urandom());
        fr = 11'h7FE;
        wr(USBSOF_OFS_ADDR, {16'hFFFF, 1'b1, ad, 8'hFF});
        wr(USBSOF_OFS_GUARD, 32'h78);
        wr(USBSOF_OFS_FRAME, {21'h0, fr});
        wr(USBSOF_OFS_TOKEN, 32'h40);
        expect_tok(USBSOF_CMD_SOF, ad, 4'h0, fr);
        // Each data and iso token once outside and once inside the guard window
        for (int k = 1; k < 7; k++) begin
            if (k == 4) continue;
            dly <= 4'($urandom_range(0, 7));
            wr(USBSOF_OFS_TOKEN, 32'(k * 16 + k + 8));
            expect_tok(3'(k), ad, 4'(k + 8), 11'h0);
            repeat (120) @(posedge clk);
            wr(USBSOF_OFS_TOKEN, 32'(k * 16 + 2));
            // Second command while one is held is dropped; window shows in status
            wr(USBSOF_OFS_TOKEN, 32'h15);
            rd(USBSOF_OFS_STATE, 32'h6, 1'b0);
            fr = fr + 11'h001;
            expect_tok(USBSOF_CMD_SOF, ad, 4'h0, fr);
            expect_tok(3'(k), ad, 4'h2, 11'h0);
        end
        rd(USBSOF_OFS_FRAME, {21'h0, fr + 11'h001}, 1'b0);
        rd(USBSOF_OFS_STATE, 32'h2, 1'b0);
        // Soft reset clears the frame number, keeps address and guard
        wr(USBSOF_OFS_CTRL, 32'h1);
        rd(USBSOF_OFS_FRAME, 32'h0, 1'b0);
        rd(USBSOF_OFS_ADDR, {17'h0, ad, 8'h0}, 1'b0);
        rd(USBSOF_OFS_GUARD, 32'h78, 1'b0);
        wr(USBSOF_OFS_CTRL, 32'h0);
        check("sof busy", {31'h0, busy}, 32'h0);
        final_report();
    end
endmodule

`default_nettype wire
